/* hw/aws_pkg.sv */
// Constants and types shared by the auto wake/sleep controller
package aws_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_INACT = 8'h29;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h2a;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h2b;
    localparam logic [7:0] ADDR_WAKE_SEL = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h2d;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL1_SLEEP_RATE_LSB = 6;
    localparam int CTRL1_WAKE_RATE_LSB = 3;
    localparam int CTRL1_ACTIVE_BIT = 0;
    localparam int CTRL2_SOFT_RST_BIT = 6;
    localparam int CTRL2_AUTO_SLEEP_BIT = 2;
    localparam int WSEL_FIFO_GATE_BIT = 7;
    localparam int WSEL_SRC_LSB = 3;
    localparam int IRQ_SW_BIT = 7;
    localparam int IRQ_SRC_LSB = 2;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Wake-capable source order inside the four-bit source fields
    localparam int SRC_FFMT = 0;
    localparam int SRC_TAP = 1;
    localparam int SRC_ORIENT = 2;
    localparam int TRANSIENT_EVENT = 3;
    localparam int NUM_SRC = 4;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BASE_PERIOD_US = 1250;
    localparam int BASE_TICK_CYCLES = BASE_PERIOD_US * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int INACT_STEP_MS = 320;
    localparam int SLOW_INACT_STEP_MS = 640;
    localparam logic [9:0] INACT_STEP_TICKS = 10'(INACT_STEP_MS * 1000 / BASE_PERIOD_US);
    localparam logic [9:0] SLOW_STEP_TICKS = 10'(SLOW_INACT_STEP_MS * 1000 / BASE_PERIOD_US);
    localparam logic [2:0] RATE_SLOWEST = 3'h7;
    localparam logic SLEEP_RATE_PREFIX = 1'b1;

    typedef enum logic [1:0] {MODE_STANDBY, MODE_WAKE, MODE_SLEEP} aws_mode_e;

    // Base ticks per sample, as a power of two: 800 Hz down to 1.56 Hz
    function automatic logic [8:0] aws_rate_mask(input logic [2:0] code);
        logic [8:0] m;
        m = 9'h000;
        unique case (code)
            3'h0: m = 9'h000;
            3'h1: m = 9'h001;
            3'h2: m = 9'h003;
            3'h3: m = 9'h007;
            3'h4: m = 9'h00f;
            3'h5: m = 9'h03f;
            3'h6: m = 9'h07f;
            3'h7: m = 9'h1ff;
        endcase
        return m;
    endfunction

endpackage

/* hw/aws_rate_tick.sv */
// Base tick and sample-rate tick divider
`timescale 1ns/1ps
module aws_rate_tick
    import aws_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_TICK_CYCLES
)
(
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [2:0] rate_code, // Effective rate code
    output logic base_tick, // One pulse per 1.25 ms
    output logic rate_tick // One pulse per sample period
);
    localparam int CW = $clog2(BASE_CYCLES);
    localparam logic [CW-1:0] CNT_MAX = CW'(BASE_CYCLES - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [8:0] pre;
    logic [8:0] next_pre;
    logic next_base;
    logic next_rate;

    always_comb
    begin
        next_cnt = cnt + CW'(1);
        next_pre = pre;
        next_base = 1'b0;
        next_rate = 1'b0;
        if (cnt == CNT_MAX)
        begin
            next_cnt = '0;
            next_pre = pre + 9'h001;
            next_base = 1'b1;
            // Free-running prescale keeps slow rates phase-aligned
            next_rate = (pre & aws_rate_mask(rate_code)) == 9'h000;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt <= '0;
            pre <= 9'h000;
            base_tick <= 1'b0;
            rate_tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            pre <= next_pre;
            base_tick <= next_base;
            rate_tick <= next_rate;
        end
    end
endmodule

/* hw/aws_ctrl.sv */
// Auto wake/sleep controller: registers, inactivity timer, mode machine
//
// Overview of operation
// - Eight-bit inactivity duration register
// - Expiry with auto-sleep enabled enters sleep
// - Sleep replaces wake rate with sleep rate
// - Step 320 ms, or 640 ms at slowest
// - Interrupt-enabled function events and FIFO events restart inactivity timer
// - Only four detection functions wake; FIFO never
// - Functions keep running at sleep rate
// - Unselected function events never wake device
// - Transition and data-ready events ignored
// - FIFO gate holds data until host flush
// - Gated FIFO refuses samples, transitions proceed
// - Auto-sleep off: standby and wake only
// - Enabled transition interrupt on every wake/sleep change, none to or from standby
// - Sleep-rate codes: 50, 12.5, 6.25, 1.56
// - Wake-rate codes: 800 down to 1.56 Hz
// - Sleep rate overrides every block's rate
`timescale 1ns/1ps
module aws_ctrl
    import aws_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_TICK_CYCLES
)
(
    input wire logic core_clk, // System clock, 200 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
    input wire logic transient_event, // Transient detected pulse
    input wire logic orientation_event, // Orientation change pulse
    input wire logic tap_event, // Tap detected pulse
    input wire logic freefall_motion_event, // Freefall/motion pulse
    input wire logic fifo_event, // FIFO gate activity pulse
    input wire logic fifo_flush, // Host flushed the FIFO
    output logic [2:0] sample_rate, // Effective rate code
    output logic sample_tick, // One pulse per sample
    output aws_mode_e sys_mode, // Standby, wake or sleep
    output logic sleep_wake_event, // Transition interrupt pulse
    output logic fifo_accept // FIFO may store samples
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] inactivity_duration, next_inactivity_duration;
    logic [7:0] system_control_one, next_system_control_one;
    logic auto_sleep_en, next_auto_sleep_en;
    logic [7:0] wake_select_reg, next_wake_select_reg;
    logic [7:0] irq_enable_reg, next_irq_enable_reg;
    logic [7:0] next_rdata;
    logic soft_rst;

    always_comb
    begin
        soft_rst = reg_wr && reg_addr == ADDR_CTRL_TWO && reg_wdata[CTRL2_SOFT_RST_BIT];
        next_inactivity_duration = inactivity_duration;
        next_system_control_one = system_control_one;
        next_auto_sleep_en = auto_sleep_en;
        next_wake_select_reg = wake_select_reg;
        next_irq_enable_reg = irq_enable_reg;
        next_rdata = reg_rdata;
        if (soft_rst)
        begin
            next_inactivity_duration = RESET_VALUE;
            next_system_control_one = RESET_VALUE;
            next_auto_sleep_en = RESET_VALUE[CTRL2_AUTO_SLEEP_BIT];
            next_wake_select_reg = RESET_VALUE;
            next_irq_enable_reg = RESET_VALUE;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_INACT: next_inactivity_duration = reg_wdata;
                ADDR_CTRL_ONE:
                begin
                    // Rate fields only change in standby
                    if (sys_mode == MODE_STANDBY)
                        next_system_control_one = reg_wdata;
                    else
                        next_system_control_one[CTRL1_ACTIVE_BIT] = reg_wdata[CTRL1_ACTIVE_BIT];
                end
                ADDR_CTRL_TWO: next_auto_sleep_en = reg_wdata[CTRL2_AUTO_SLEEP_BIT];
                ADDR_WAKE_SEL: next_wake_select_reg = reg_wdata;
                ADDR_IRQ_EN: next_irq_enable_reg = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_INACT: next_rdata = inactivity_duration;
                ADDR_CTRL_ONE: next_rdata = system_control_one;
                ADDR_CTRL_TWO: next_rdata = {5'h00, auto_sleep_en, 2'h0};
                ADDR_WAKE_SEL: next_rdata = wake_select_reg;
                ADDR_IRQ_EN: next_rdata = irq_enable_reg;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            inactivity_duration <= RESET_VALUE;
            system_control_one <= RESET_VALUE;
            auto_sleep_en <= RESET_VALUE[CTRL2_AUTO_SLEEP_BIT];
            wake_select_reg <= RESET_VALUE;
            irq_enable_reg <= RESET_VALUE;
            reg_rdata <= 8'h00;
        end
        else
        begin
            inactivity_duration <= next_inactivity_duration;
            system_control_one <= next_system_control_one;
            auto_sleep_en <= next_auto_sleep_en;
            wake_select_reg <= next_wake_select_reg;
            irq_enable_reg <= next_irq_enable_reg;
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Rate selection and ticks
    // ----------------------------------------
    logic active;
    logic [2:0] wake_rate_sel;
    logic [1:0] sleep_rate_sel;
    logic base_tick;

    assign active = system_control_one[CTRL1_ACTIVE_BIT];
    assign wake_rate_sel = system_control_one[CTRL1_WAKE_RATE_LSB +: 3];
    assign sleep_rate_sel = system_control_one[CTRL1_SLEEP_RATE_LSB +: 2];
    // Sleep codes map onto the four slowest wake codes
    assign sample_rate = (sys_mode == MODE_SLEEP) ? {SLEEP_RATE_PREFIX, sleep_rate_sel}
                                                   : wake_rate_sel;

    aws_rate_tick #(.BASE_CYCLES(BASE_CYCLES)) u_tick
    (
        .core_clk(core_clk),
        .rst(rst),
        .rate_code(sample_rate),
        .base_tick(base_tick),
        .rate_tick(sample_tick)
    );

    // ----------------------------------------
    // Inactivity timer
    // ----------------------------------------
    logic [NUM_SRC-1:0] src_vec;
    logic [NUM_SRC-1:0] src_irq_en;
    logic [NUM_SRC-1:0] src_wake_sel;
    logic restart_hit;
    logic wake_hit;
    logic expired;
    logic [9:0] step_limit;
    logic [9:0] step_cnt, next_step_cnt;
    logic [7:0] inact_steps, next_inact_steps;

    assign src_vec = {transient_event, orientation_event, tap_event, freefall_motion_event};
    assign src_irq_en = irq_enable_reg[IRQ_SRC_LSB +: NUM_SRC];
    assign src_wake_sel = wake_select_reg[WSEL_SRC_LSB +: NUM_SRC];
    // Transition and data-ready events are not inputs here at all
    assign restart_hit = |(src_vec & src_irq_en) || fifo_event;
    assign wake_hit = |(src_vec & src_irq_en & src_wake_sel);
    assign step_limit = (wake_rate_sel == RATE_SLOWEST) ? SLOW_STEP_TICKS
                                                        : INACT_STEP_TICKS;
    assign expired = inact_steps >= inactivity_duration;

    always_comb
    begin
        next_step_cnt = step_cnt;
        next_inact_steps = inact_steps;
        if (sys_mode != MODE_WAKE || restart_hit || soft_rst)
        begin
            next_step_cnt = 10'h000;
            next_inact_steps = 8'h00;
        end
        else if (base_tick)
        begin
            if (step_cnt == step_limit - 10'h001)
            begin
                next_step_cnt = 10'h000;
                if (inact_steps != 8'hff)
                    next_inact_steps = inact_steps + 8'h01;
            end
            else
                next_step_cnt = step_cnt + 10'h001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            step_cnt <= 10'h000;
            inact_steps <= 8'h00;
        end
        else
        begin
            step_cnt <= next_step_cnt;
            inact_steps <= next_inact_steps;
        end
    end

    // ----------------------------------------
    // Mode machine, transition event, FIFO gate
    // ----------------------------------------
    aws_mode_e next_mode;
    logic sw_change;
    logic fifo_hold, next_fifo_hold;
    logic next_sw_event;

    always_comb
    begin
        next_mode = sys_mode;
        unique case (sys_mode)
            MODE_STANDBY: if (active) next_mode = MODE_WAKE;
            MODE_WAKE:
            begin
                if (!active)
                    next_mode = MODE_STANDBY;
                else if (auto_sleep_en && expired)
                    next_mode = MODE_SLEEP;
            end
            MODE_SLEEP:
            begin
                if (!active)
                    next_mode = MODE_STANDBY;
                else if (!auto_sleep_en || wake_hit)
                    next_mode = MODE_WAKE;
            end
            default: next_mode = MODE_STANDBY;
        endcase
        if (soft_rst)
            next_mode = MODE_STANDBY;
        sw_change = (sys_mode == MODE_WAKE && next_mode == MODE_SLEEP)
                 || (sys_mode == MODE_SLEEP && next_mode == MODE_WAKE);
        next_sw_event = sw_change && irq_enable_reg[IRQ_SW_BIT];
        // A transition in the flush cycle still holds the FIFO
        next_fifo_hold = (sw_change && wake_select_reg[WSEL_FIFO_GATE_BIT])
                      || (fifo_hold && !fifo_flush && !soft_rst);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sys_mode <= MODE_STANDBY;
            sleep_wake_event <= 1'b0;
            fifo_hold <= 1'b0;
        end
        else
        begin
            sys_mode <= next_mode;
            sleep_wake_event <= next_sw_event;
            fifo_hold <= next_fifo_hold;
        end
    end

    assign fifo_accept = !fifo_hold;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_fall_asleep;
        sys_mode == MODE_WAKE && irq_enable_reg[IRQ_SW_BIT] ##1 sys_mode == MODE_SLEEP;
    endsequence

    sequence s_gated_change;
        sw_change && wake_select_reg[WSEL_FIFO_GATE_BIT] ##1 !fifo_flush;
    endsequence

    a_sleep_needs_enable: assert property ($rose(sys_mode == MODE_SLEEP) |-> $past(auto_sleep_en))
        else $error("sleep entered without auto-sleep enable");
    a_sleep_rate_used: assert property (sys_mode == MODE_SLEEP |-> sample_rate == {1'b1, sleep_rate_sel})
        else $error("sleep rate not applied");
    a_wake_rate_used: assert property (sys_mode == MODE_WAKE |-> sample_rate == wake_rate_sel)
        else $error("wake rate not applied");
    a_expire_sleeps: assert property (sys_mode == MODE_WAKE && active && auto_sleep_en && expired && !soft_rst |=> sys_mode == MODE_SLEEP)
        else $error("expiry did not enter sleep");
    a_no_stray_wake: assert property (sys_mode == MODE_SLEEP && active && auto_sleep_en && !wake_hit && !soft_rst |=> sys_mode == MODE_SLEEP)
        else $error("left sleep without a selected source");
    a_wake_clears_timer: assert property ($rose(sys_mode == MODE_WAKE) |-> inact_steps == 8'h00 && step_cnt == 10'h000)
        else $error("inactivity count not cleared on wake");
    a_restart_clears: assert property (sys_mode == MODE_WAKE && restart_hit |=> inact_steps == 8'h00 && step_cnt == 10'h000)
        else $error("event did not restart inactivity timer");
    a_step_bound: assert property (step_cnt < step_limit || $changed(wake_rate_sel))
        else $error("step counter beyond step weight");
    a_sleep_irq: assert property (s_fall_asleep |-> sleep_wake_event)
        else $error("no interrupt on falling asleep");
    a_fifo_refuses: assert property (s_gated_change |-> !fifo_accept ##1 (fifo_accept == $past(fifo_flush)))
        else $error("gated FIFO accepted before flush");
    a_soft_reset: assert property (soft_rst |=> !auto_sleep_en && sys_mode == MODE_STANDBY)
        else $error("soft reset left auto-sleep enabled");
endmodule

/* bench/aws_host_model.sv */
// Host processor model: register master and FIFO flush for the controller
`timescale 1ns/1ps
module aws_host_model
    import aws_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic [7:0] reg_rdata, // Read data from the device
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Register offset
    output logic [7:0] reg_wdata, // Write data
    output logic fifo_flush // FIFO flush pulse
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fifo_flush = 1'b0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Released fields flip so a stale value is never read as a fresh one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    task automatic flush();
        @(posedge core_clk);
        fifo_flush <= 1'b1;
        @(posedge core_clk);
        fifo_flush <= 1'b0;
        #1;
    endtask
    // Both the interrupt enable and the wake select are needed to wake
    task automatic wake_cfg(input logic [3:0] irq, input logic [3:0] sel, input logic gate);
        wr(ADDR_IRQ_EN, {1'b1, 1'b0, irq, 2'b00});
        wr(ADDR_WAKE_SEL, {gate, sel, 3'b000});
    endtask
    task automatic auto_sleep(input logic on);
        wr(ADDR_CTRL_TWO, {5'h00, on, 2'b00});
    endtask
endmodule

/* bench/aws_ctrl_tb_top.sv */
// Self-checking testbench for the auto wake/sleep controller
`timescale 1ns/1ps
module aws_ctrl_tb_top
    import aws_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} aws_row_s;
    // Short base tick keeps a 320 ms step at 1024 clocks
    localparam int BASE = 4;
    localparam int TICKS [8] = '{1, 2, 4, 8, 16, 64, 128, 512};
    localparam aws_row_s ROWS [7] = '{'{ADDR_INACT, 8'ha5, 8'ha5},
        '{ADDR_CTRL_ONE, 8'he8, 8'he8}, '{ADDR_CTRL_TWO, 8'h04, 8'h04},
        '{ADDR_WAKE_SEL, 8'hf8, 8'hf8}, '{ADDR_IRQ_EN, 8'hbc, 8'hbc},
        '{8'h30, 8'h5a, 8'h00}, '{8'h28, 8'h11, 8'h00}};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] evt = 4'h0;
    logic fifo_ev = 1'b0;
    logic reg_wr, reg_rd, fifo_flush, sample_tick, sleep_wake_event, fifo_accept;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] sample_rate;
    aws_mode_e sys_mode;
    int num_errors = 0;
    int checked = 0;
    int sw_cnt = 0;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (sleep_wake_event === 1'b1) sw_cnt++;
    aws_ctrl #(.BASE_CYCLES(BASE)) dut
    (
        .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .transient_event(evt[TRANSIENT_EVENT]), .orientation_event(evt[SRC_ORIENT]),
        .tap_event(evt[SRC_TAP]), .freefall_motion_event(evt[SRC_FFMT]),
        .fifo_event(fifo_ev), .fifo_flush(fifo_flush), .sample_rate(sample_rate),
        .sample_tick(sample_tick), .sys_mode(sys_mode),
        .sleep_wake_event(sleep_wake_event), .fifo_accept(fifo_accept)
    );
    aws_host_model h
    (
        .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .fifo_flush(fifo_flush)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic close_out();
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic chk_mode(input string nm, input aws_mode_e e, input aws_mode_e g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic wait_mode(input aws_mode_e m, input int lim, output int n);
        n = 0;
        while (sys_mode !== m && n < lim)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk_mode("sys_mode", m, sys_mode);
    endtask
    // Cycles between two sample ticks
    task automatic gap(output int n);
        int k;
        k = 0;
        while (sample_tick !== 1'b1 && k < 3000)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (sample_tick !== 1'b1 && n < 3000);
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge core_clk);
        {fifo_ev, evt} <= m;
        @(posedge core_clk);
        {fifo_ev, evt} <= 5'h00;
        #1;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] d;
        int n;
        int s0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk_mode("reset mode", MODE_STANDBY, sys_mode);
        chk_val("reset fifo_accept", 16'h1, 16'(fifo_accept));
        for (int i = 0; i < 5; i++)
        begin
            h.rd(ROWS[i].addr, d);
            chk_val("reset value", 16'h0, 16'(d));
        end
        foreach (ROWS[i])
        begin
            h.wr(ROWS[i].addr, ROWS[i].wdata);
            h.rd(ROWS[i].addr, d);
            chk_val("readback", 16'(ROWS[i].rexp), 16'(d));
        end
        h.wr(ADDR_CTRL_TWO, 8'h44);
        h.rd(ADDR_INACT, d);
        chk_val("duration after soft reset", 16'h0, 16'(d));
        h.rd(ADDR_CTRL_TWO, d);
        chk_val("control two after soft reset", 16'h0, 16'(d));
        for (int c = 0; c < 8; c++)
        begin
            h.wr(ADDR_CTRL_ONE, {2'b00, 3'(c), 3'b001});
            wait_mode(MODE_WAKE, 4, n);
            gap(n);
            chk_val("wake rate", 16'(c), 16'(sample_rate));
            chk_val("wake tick gap", 16'(TICKS[c] * BASE), 16'(n));
            chk_mode("auto-sleep off", MODE_WAKE, sys_mode);
            h.wr(ADDR_CTRL_ONE, 8'h00);
        end
        h.wake_cfg(4'hf, 4'hf, 1'b1);
        h.auto_sleep(1'b1);
        for (int s = 0; s < 4; s++)
        begin
            s0 = sw_cnt;
            h.wr(ADDR_CTRL_ONE, {2'(s), 3'h1, 3'b001});
            wait_mode(MODE_SLEEP, 8, n);
            gap(n);
            chk_val("sleep rate", 16'({1'b1, 2'(s)}), 16'(sample_rate));
            chk_val("sleep tick gap", 16'(TICKS[4 + s] * BASE), 16'(n));
            chk_val("fifo held", 16'h0, 16'(fifo_accept));
            chk_val("sleep events", 16'h1, 16'(sw_cnt - s0));
            h.flush();
            @(posedge core_clk);
            #1;
            chk_val("fifo resumed", 16'h1, 16'(fifo_accept));
            h.wr(ADDR_CTRL_ONE, 8'h00);
        end
        h.wake_cfg(4'hf, 4'h1, 1'b0);
        h.wr(ADDR_INACT, 8'h01);
        s0 = sw_cnt;
        h.wr(ADDR_CTRL_ONE, 8'h01);
        wait_mode(MODE_SLEEP, 1100, n);
        chk_val("sleep delay", 16'h1, 16'(n >= 1016 && n <= 1040));
        pulse(5'h10 | 5'(1 << SRC_TAP));
        repeat (4) @(posedge core_clk);
        #1;
        chk_mode("unselected or fifo wake", MODE_SLEEP, sys_mode);
        pulse(5'(1 << SRC_FFMT));
        wait_mode(MODE_WAKE, 2, n);
        chk_val("woken rate", 16'h0, 16'(sample_rate));
        repeat (600) @(posedge core_clk);
        pulse(5'(1 << SRC_TAP));
        wait_mode(MODE_SLEEP, 1100, n);
        chk_val("restarted delay", 16'h1, 16'(n >= 1014 && n <= 1040));
        chk_val("sleep event pulse", 16'h1, 16'(sleep_wake_event));
        // Counter sees the pulse one edge after it is launched
        @(posedge core_clk);
        #1;
        chk_val("wake events", 16'h3, 16'(sw_cnt - s0));
        s0 = sw_cnt;
        h.wr(ADDR_CTRL_ONE, 8'h00);
        h.wr(ADDR_CTRL_ONE, 8'h39);
        wait_mode(MODE_SLEEP, 2200, n);
        chk_val("slow sleep delay", 16'h1, 16'(n >= 2040 && n <= 2060));
        h.auto_sleep(1'b0);
        wait_mode(MODE_WAKE, 4, n);
        @(posedge core_clk);
        #1;
        chk_val("auto-sleep off events", 16'h2, 16'(sw_cnt - s0));
        h.wr(ADDR_CTRL_ONE, 8'hc1);
        h.rd(ADDR_CTRL_ONE, d);
        chk_val("rates locked in wake", 16'h39, 16'(d));
        close_out();
    end
    // Expected run is near 13000 cycles; the limit leaves ample margin
    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule
